// ---- rtl/ttc_core.sv ----
`timescale 1ns/10ps
module ttc_core
	import ttc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_standby,
	input wire logic [4:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [1:0] i_be,
	input wire logic [15:0] i_wdata,
	input wire logic [3:0] i_ext_clk,
	input wire logic [2:0] i_capture_a,
	input wire logic [2:0] i_capture_b,
	output logic [15:0] o_rdata,
	output logic o_ch0_wrap_irq,
	output logic o_ch1_wrap_irq,
	output logic o_ch2_wrap_irq
);
	// ==================================================
	// state and helper terms
	ttc_state_type s_q;
	ttc_state_type s_d;
	logic [2:0] tick;
	logic [2:0] up;
	logic [2:0] cap_a;
	logic [2:0] cap_b;
	logic [2:0] match_a;
	logic [2:0] match_b;
	logic [2:0] own_clr;
	logic [2:0] clr;
	logic [2:0] wrap_set;
	logic [2:0] wr_cnt;
	logic phase;
	logic [1:0] sel;
	logic [2:0] psc;
	logic [7:0] wlo;
	logic [15:0] rd_mux;

	// ==================================================
	// next-state logic
	always_comb begin
		s_d = s_q;
		tick = '0;
		up = '0;
		cap_a = '0;
		cap_b = '0;
		match_a = '0;
		match_b = '0;
		own_clr = '0;
		clr = '0;
		wrap_set = '0;
		wr_cnt = '0;
		sel = '0;
		psc = '0;
		wlo = i_wdata[7:0];
		rd_mux = '0;
		phase = s_q.mode[TTC_PHASE_BIT];
		// pins pass two flops; only the second stage and its delayed copy feed logic
		s_d.ext_m = i_ext_clk;
		s_d.ext_s = s_q.ext_m;
		s_d.ext_p = s_q.ext_s;
		s_d.cap_m = {i_capture_b, i_capture_a};
		s_d.cap_s = s_q.cap_m;
		s_d.cap_p = s_q.cap_s;
		s_d.pre = s_q.pre + 3'h1;
		// count source, direction, compare and capture per channel
		for (int i = 0; i < 3; i++) begin
			psc = s_q.ctrl[i][2:0];
			up[i] = 1'h1;
			unique case (psc)
				3'h0: tick[i] = 1'h1;
				3'h1: tick[i] = s_q.pre[0];
				3'h2: tick[i] = &s_q.pre[1:0];
				3'h3: tick[i] = &s_q.pre;
				3'h4, 3'h5, 3'h6, 3'h7: tick[i] = ttc_edge(s_q.ext_p[psc[1:0]], s_q.ext_s[psc[1:0]], s_q.ctrl[i][4:3]);
			endcase
			if (i == 2 && phase) begin
				// quadrature on external inputs A and B; either edge counts
				tick[i] = (s_q.ext_s[0] ^ s_q.ext_p[0]) | (s_q.ext_s[1] ^ s_q.ext_p[1]);
				up[i] = s_q.ext_s[0] ^ s_q.ext_p[1];
			end
			// pwm forces compare use regardless of the I/O selection
			if (!s_q.mode[i] && s_q.ioc[i][TTC_CAP_A_BIT]) begin
				cap_a[i] = ttc_edge(s_q.cap_p[i], s_q.cap_s[i], s_q.ioc[i][1:0]);
			end else begin
				match_a[i] = tick[i] && (s_q.cnt[i] == s_q.general_reg_a[i]);
			end
			if (!s_q.mode[i] && s_q.ioc[i][TTC_CAP_B_BIT]) begin
				cap_b[i] = ttc_edge(s_q.cap_p[i+3], s_q.cap_s[i+3], s_q.ioc[i][5:4]);
			end else begin
				match_b[i] = tick[i] && (s_q.cnt[i] == s_q.general_reg_b[i]);
			end
			sel = s_q.ctrl[i][6:5];
			own_clr[i] = (sel == TTC_CLR_A && (match_a[i] || cap_a[i])) ||
				(sel == TTC_CLR_B && (match_b[i] || cap_b[i]));
		end
		// synchronous clear follows any channel that clears on its own
		for (int i = 0; i < 3; i++) begin
			clr[i] = own_clr[i] || (s_q.ctrl[i][6:5] == TTC_CLR_SYNC && |own_clr);
			if (clr[i]) begin
				s_d.cnt[i] = TTC_CNT_RST;
			end else if (tick[i]) begin
				s_d.cnt[i] = up[i] ? s_q.cnt[i] + 16'h0001 : s_q.cnt[i] - 16'h0001;
				wrap_set[i] = up[i] ? (s_q.cnt[i] == TTC_CNT_MAX) : (s_q.cnt[i] == TTC_CNT_RST);
			end
		end
		// read mux: reserved bits read as one, unmapped words as zero
		unique case (i_addr)
			TTC_OFF_OVF: rd_mux = {8'h00, TTC_RSV_MASK | {1'h0, s_q.ovie, 1'h0, s_q.ovf}};
			TTC_OFF_FLA: rd_mux = {8'h00, TTC_RSV_MASK | {1'h0, s_q.fa_en, 1'h0, s_q.fa}};
			TTC_OFF_FLB: rd_mux = {8'h00, TTC_RSV_MASK | {1'h0, s_q.fb_en, 1'h0, s_q.fb}};
			TTC_OFF_MODE: rd_mux = {8'h00, s_q.mode};
			TTC_OFF_CTRL0, 5'h05, 5'h06: rd_mux = {8'h00, s_q.ctrl[i_addr - TTC_OFF_CTRL0]};
			TTC_OFF_IOC0, 5'h08, 5'h09: rd_mux = {8'h00, s_q.ioc[i_addr - TTC_OFF_IOC0]};
			TTC_OFF_CNT0, 5'h0B, 5'h0C: rd_mux = s_q.cnt[i_addr - TTC_OFF_CNT0];
			TTC_OFF_CHANNEL0_GENERAL_A, 5'h0E, 5'h0F: rd_mux = s_q.general_reg_a[i_addr - TTC_OFF_CHANNEL0_GENERAL_A];
			TTC_OFF_CHANNEL0_GENERAL_B, 5'h11, 5'h12: rd_mux = s_q.general_reg_b[i_addr - TTC_OFF_CHANNEL0_GENERAL_B];
			default: rd_mux = '0;
		endcase
		if (i_rd) begin
			s_d.rdata = rd_mux;
			// a flag seen as one arms its own clear
			if (i_addr == TTC_OFF_OVF) s_d.ovf_arm = s_q.ovf_arm | s_q.ovf;
			if (i_addr == TTC_OFF_FLA) s_d.fa_arm = s_q.fa_arm | s_q.fa;
			if (i_addr == TTC_OFF_FLB) s_d.fb_arm = s_q.fb_arm | s_q.fb;
		end
		// register writes; 8-bit registers sit in the low byte lane
		if (i_wr && i_be[0]) begin
			if (i_addr == TTC_OFF_OVF) begin
				s_d.ovie = wlo[6:4];
				s_d.ovf = s_q.ovf & ~(s_q.ovf_arm & ~wlo[2:0]);
				s_d.ovf_arm = '0;
			end
			if (i_addr == TTC_OFF_FLA) begin
				s_d.fa_en = wlo[6:4];
				s_d.fa = s_q.fa & ~(s_q.fa_arm & ~wlo[2:0]);
				s_d.fa_arm = '0;
			end
			if (i_addr == TTC_OFF_FLB) begin
				s_d.fb_en = wlo[6:4];
				s_d.fb = s_q.fb & ~(s_q.fb_arm & ~wlo[2:0]);
				s_d.fb_arm = '0;
			end
			if (i_addr == TTC_OFF_MODE) s_d.mode = wlo;
		end
		for (int i = 0; i < 3; i++) begin
			if (i_wr && i_be[0] && i_addr == 5'(TTC_OFF_CTRL0 + i)) s_d.ctrl[i] = wlo | TTC_RST_CTRL;
			if (i_wr && i_be[0] && i_addr == 5'(TTC_OFF_IOC0 + i)) s_d.ioc[i] = wlo | TTC_RSV_MASK;
			// bus write to a counter takes priority over counting
			wr_cnt[i] = i_wr && i_addr == 5'(TTC_OFF_CNT0 + i);
			if (wr_cnt[i]) s_d.cnt[i] = ttc_merge(s_q.cnt[i], i_wdata, i_be);
			if (i_wr && i_addr == 5'(TTC_OFF_CHANNEL0_GENERAL_A + i)) s_d.general_reg_a[i] = ttc_merge(s_q.general_reg_a[i], i_wdata, i_be);
			if (i_wr && i_addr == 5'(TTC_OFF_CHANNEL0_GENERAL_B + i)) s_d.general_reg_b[i] = ttc_merge(s_q.general_reg_b[i], i_wdata, i_be);
			// a capture edge beats a simultaneous bus write
			if (cap_a[i]) s_d.general_reg_a[i] = s_q.cnt[i];
			if (cap_b[i]) s_d.general_reg_b[i] = s_q.cnt[i];
		end
		// hardware sets after software clears, so a coincident event survives
		s_d.ovf = s_d.ovf | wrap_set;
		s_d.fa = s_d.fa | match_a | cap_a;
		s_d.fb = s_d.fb | match_b | cap_b;
		// standby reinitialises registers but keeps the pin samplers running
		if (i_standby) begin
			s_d = TTC_STATE_RST;
			s_d.ext_m = i_ext_clk;
			s_d.ext_s = s_q.ext_m;
			s_d.ext_p = s_q.ext_s;
			s_d.cap_m = {i_capture_b, i_capture_a};
			s_d.cap_s = s_q.cap_m;
			s_d.cap_p = s_q.cap_s;
			// read path survives standby so a host still sees the reset values
			s_d.rdata = i_rd ? rd_mux : s_q.rdata;
		end
		s_d.irq = s_d.ovf & s_d.ovie;
	end

	// ==================================================
	// state register
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= TTC_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rdata = s_q.rdata;
	assign o_ch0_wrap_irq = s_q.irq[0];
	assign o_ch1_wrap_irq = s_q.irq[1];
	assign o_ch2_wrap_irq = s_q.irq[2];

	// ==================================================
	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	sequence s_armed0;
		i_rd && !i_wr && i_addr == TTC_OFF_OVF && s_q.ovf[0];
	endsequence
	sequence s_clear0;
		i_wr && i_be[0] && i_addr == TTC_OFF_OVF && !i_wdata[0] && !wrap_set[0] && !i_standby;
	endsequence
	property p_read_write_clear;
		s_armed0 ##1 s_clear0 |=> !s_q.ovf[0];
	endproperty
	a_read_write_clear: assert property (p_read_write_clear) else $error("flag not cleared");

	property p_no_blind_clear;
		s_q.ovf[0] && !s_q.ovf_arm[0] && !i_standby |=> s_q.ovf[0];
	endproperty
	a_no_blind_clear: assert property (p_no_blind_clear) else $error("flag cleared unread");

	property p_wrap_sets;
		wrap_set != 3'h0 && !i_standby |=> (s_q.ovf & $past(wrap_set)) == $past(wrap_set);
	endproperty
	a_wrap_sets: assert property (p_wrap_sets) else $error("wrap flag missed");

	property p_irq;
		##1 (o_ch0_wrap_irq == (s_q.ovf[0] && s_q.ovie[0]))
			&& (o_ch1_wrap_irq == (s_q.ovf[1] && s_q.ovie[1]))
			&& (o_ch2_wrap_irq == (s_q.ovf[2] && s_q.ovie[2]));
	endproperty
	a_irq: assert property (p_irq) else $error("wrap request wrong");

	property p_reserved_one;
		i_rd && i_addr == TTC_OFF_OVF |=> o_rdata[TTC_RSV_LO] && o_rdata[TTC_RSV_HI];
	endproperty
	a_reserved_one: assert property (p_reserved_one) else $error("reserved bit not one");

	property p_ch0_up_only;
		!$past(wr_cnt[0]) && !$past(clr[0]) && !$past(i_standby) |-> s_q.cnt[0] != $past(s_q.cnt[0]) - 16'h0001;
	endproperty
	a_ch0_up_only: assert property (p_ch0_up_only) else $error("channel 0 counted down");

	property p_no_down_unphased;
		!phase && !wr_cnt[2] && !clr[2] && !i_standby |=>
			16'(s_q.cnt[2] - $past(s_q.cnt[2])) <= 16'h0001;
	endproperty
	a_no_down_unphased: assert property (p_no_down_unphased) else $error("down count outside phase mode");

	property p_standby;
		i_standby |=> s_q.cnt == {3{TTC_CNT_RST}} && s_q.general_reg_a == {3{TTC_GR_RST}} && s_q.ioc == {3{TTC_RST_IOC}};
	endproperty
	a_standby: assert property (p_standby) else $error("standby init wrong");

	property p_capture;
		cap_a[2] && !i_standby |=> s_q.general_reg_a[2] == $past(s_q.cnt[2]) && s_q.fa[2];
	endproperty
	a_capture: assert property (p_capture) else $error("capture not taken");

	property p_match_clear;
		match_a[1] && s_q.ctrl[1][6:5] == TTC_CLR_A && !wr_cnt[1] && !i_standby |=> s_q.cnt[1] == 16'h0000 && s_q.fa[1];
	endproperty
	a_match_clear: assert property (p_match_clear) else $error("match clear failed");

	sequence s_host_gap;
		(!i_wr && !i_rd) [*2];
	endsequence
	property p_read_gap_clear;
		s_armed0 ##1 s_host_gap ##1 s_clear0 |=> !s_q.ovf[0];
	endproperty
	a_read_gap_clear: assert property (p_read_gap_clear) else $error("flag not cleared after gap");

	property p_write_one_keeps;
		s_q.ovf[0] && i_wr && i_be[0] && i_addr == TTC_OFF_OVF && i_wdata[0] && !i_standby |=> s_q.ovf[0];
	endproperty
	a_write_one_keeps: assert property (p_write_one_keeps) else $error("flag cleared by a one");

	property p_enable_write;
		i_wr && i_be[0] && i_addr == TTC_OFF_OVF && !i_standby |=> s_q.ovie == $past(i_wdata[6:4]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable not written");

	property p_ch0_wrap;
		tick[0] && !clr[0] && !wr_cnt[0] && s_q.cnt[0] == TTC_CNT_MAX && !i_standby |=>
			s_q.cnt[0] == TTC_CNT_RST && s_q.ovf[0];
	endproperty
	a_ch0_wrap: assert property (p_ch0_wrap) else $error("channel 0 wrap missed");

	property p_ch1_set_only_on_wrap;
		!s_q.ovf[1] && !wrap_set[1] |=> !s_q.ovf[1];
	endproperty
	a_ch1_set_only_on_wrap: assert property (p_ch1_set_only_on_wrap) else $error("flag set without wrap");

	property p_ch2_underflow;
		phase && tick[2] && !up[2] && !clr[2] && !wr_cnt[2] && !i_standby && s_q.cnt[2] == TTC_CNT_RST |=>
			s_q.cnt[2] == TTC_CNT_MAX && s_q.ovf[2];
	endproperty
	a_ch2_underflow: assert property (p_ch2_underflow) else $error("underflow missed");

	property p_cnt_byte_write;
		i_wr && i_addr == TTC_OFF_CNT0 && !i_standby |=>
			s_q.cnt[0][7:0] == ($past(i_be[0]) ? $past(i_wdata[7:0]) : $past(s_q.cnt[0][7:0])) &&
			s_q.cnt[0][15:8] == ($past(i_be[1]) ? $past(i_wdata[15:8]) : $past(s_q.cnt[0][15:8]));
	endproperty
	a_cnt_byte_write: assert property (p_cnt_byte_write) else $error("counter lane write wrong");

	property p_gr_low_lane;
		i_wr && i_be[0] && i_addr == TTC_OFF_CHANNEL0_GENERAL_B && !cap_b[0] && !i_standby |=>
			s_q.general_reg_b[0][7:0] == $past(i_wdata[7:0]);
	endproperty
	a_gr_low_lane: assert property (p_gr_low_lane) else $error("register low lane wrong");

	property p_compare_sets;
		!s_q.ioc[0][TTC_CAP_A_BIT] && tick[0] && s_q.cnt[0] == s_q.general_reg_a[0] && !i_standby |=>
			s_q.fa[0];
	endproperty
	a_compare_sets: assert property (p_compare_sets) else $error("compare flag missed");

	property p_compare_kept;
		!s_q.ioc[1][TTC_CAP_A_BIT] && !(i_wr && i_addr == TTC_OFF_CHANNEL0_GENERAL_A + 5'h01) && !i_standby |=>
			s_q.general_reg_a[1] == $past(s_q.general_reg_a[1]);
	endproperty
	a_compare_kept: assert property (p_compare_kept) else $error("compare register changed");

	property p_pwm_ignores_capture;
		s_q.mode[2] && !(i_wr && i_addr == TTC_OFF_CHANNEL0_GENERAL_A + 5'h02) && !i_standby |=>
			s_q.general_reg_a[2] == $past(s_q.general_reg_a[2]);
	endproperty
	a_pwm_ignores_capture: assert property (p_pwm_ignores_capture) else $error("capture in pwm mode");

	property p_standby_rest;
		i_standby |=>
			s_q.general_reg_b == {3{TTC_GR_RST}} && s_q.ctrl == {3{TTC_RST_CTRL}} && s_q.ovf == 3'h0;
	endproperty
	a_standby_rest: assert property (p_standby_rest) else $error("standby init incomplete");

	property p_sync_clear;
		|own_clr && s_q.ctrl[0][6:5] == TTC_CLR_SYNC && !wr_cnt[0] && !i_standby |=>
			s_q.cnt[0] == TTC_CNT_RST;
	endproperty
	a_sync_clear: assert property (p_sync_clear) else $error("synchronous clear missed");

	property p_rdata_hold;
		!i_rd |=> $stable(o_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed unread");
endmodule

// ---- rtl/ttc_pkg.sv ----
package ttc_pkg;
	// ==================================================
	// register word offsets on the internal 16-bit bus
	localparam logic [4:0] TTC_OFF_OVF = 5'h00;
	localparam logic [4:0] TTC_OFF_FLA = 5'h01;
	localparam logic [4:0] TTC_OFF_FLB = 5'h02;
	localparam logic [4:0] TTC_OFF_MODE = 5'h03;
	localparam logic [4:0] TTC_OFF_CTRL0 = 5'h04;
	localparam logic [4:0] TTC_OFF_IOC0 = 5'h07;
	localparam logic [4:0] TTC_OFF_CNT0 = 5'h0A;
	localparam logic [4:0] TTC_OFF_CHANNEL0_GENERAL_A = 5'h0D;
	localparam logic [4:0] TTC_OFF_CHANNEL0_GENERAL_B = 5'h10;
	// ==================================================
	// field positions
	localparam int TTC_RSV_HI = 7;
	localparam int TTC_RSV_LO = 3;
	localparam int TTC_EN_LSB = 4;
	localparam int TTC_PHASE_BIT = 6;
	localparam int TTC_CAP_A_BIT = 2;
	localparam int TTC_CAP_B_BIT = 6;
	localparam logic [1:0] TTC_CLR_A = 2'h1;
	localparam logic [1:0] TTC_CLR_B = 2'h2;
	localparam logic [1:0] TTC_CLR_SYNC = 2'h3;
	// ==================================================
	// values after reset and standby
	localparam logic [7:0] TTC_RST_STAT = 8'h88;
	localparam logic [7:0] TTC_RST_CTRL = 8'h80;
	localparam logic [7:0] TTC_RST_IOC = 8'h88;
	localparam logic [7:0] TTC_RST_MODE = 8'h00;
	localparam logic [7:0] TTC_RSV_MASK = 8'h88;
	localparam logic [15:0] TTC_CNT_RST = 16'h0000;
	localparam logic [15:0] TTC_GR_RST = 16'hFFFF;
	localparam logic [15:0] TTC_CNT_MAX = 16'hFFFF;

	typedef struct packed {
		logic [2:0][15:0] cnt;
		logic [2:0][15:0] general_reg_a;
		logic [2:0][15:0] general_reg_b;
		logic [2:0][7:0] ctrl;
		logic [2:0][7:0] ioc;
		logic [7:0] mode;
		logic [2:0] ovf;
		logic [2:0] ovie;
		logic [2:0] ovf_arm;
		logic [2:0] fa;
		logic [2:0] fa_en;
		logic [2:0] fa_arm;
		logic [2:0] fb;
		logic [2:0] fb_en;
		logic [2:0] fb_arm;
		logic [2:0] pre;
		logic [3:0] ext_m;
		logic [3:0] ext_s;
		logic [3:0] ext_p;
		logic [5:0] cap_m;
		logic [5:0] cap_s;
		logic [5:0] cap_p;
		logic [2:0] irq;
		logic [15:0] rdata;
	} ttc_state_type;

	localparam ttc_state_type TTC_STATE_RST = '{cnt: {3{TTC_CNT_RST}}, general_reg_a: {3{TTC_GR_RST}},
		general_reg_b: {3{TTC_GR_RST}}, ctrl: {3{TTC_RST_CTRL}}, ioc: {3{TTC_RST_IOC}}, mode: TTC_RST_MODE, default: '0};

	// edge select: 00 rising, 01 falling, 1x both
	function automatic logic ttc_edge(input logic prev, input logic cur, input logic [1:0] sel);
		ttc_edge = sel[1] ? (prev ^ cur) : (sel[0] ? (prev & ~cur) : (~prev & cur));
	endfunction

	function automatic logic [15:0] ttc_merge(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
		ttc_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction
endpackage

// ---- tb/ttc_core_tb.sv ----
`timescale 1ns/10ps
// ==================================================
// bench: host model drives the bus, integer model predicts status and requests
module ttc_core_tb;
	import ttc_pkg::*;
	logic i_core_clk, i_rst, i_standby, i_wr, i_rd;
	logic [4:0] i_addr;
	logic [1:0] i_be;
	logic [15:0] i_wdata, o_rdata, v, r;
	logic [3:0] i_ext_clk;
	logic [2:0] i_capture_a, i_capture_b, irqs;
	logic [31:0] seed = 32'hBAE040DB;
	int mismatches = 0, checks_done = 0, en_m = 0, fl_m = 0;
	ttc_core ttc_core_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_standby(i_standby), .i_addr(i_addr),
		.i_wr(i_wr), .i_rd(i_rd), .i_be(i_be), .i_wdata(i_wdata), .i_ext_clk(i_ext_clk),
		.i_capture_a(i_capture_a), .i_capture_b(i_capture_b), .o_rdata(o_rdata),
		.o_ch0_wrap_irq(irqs[0]), .o_ch1_wrap_irq(irqs[1]), .o_ch2_wrap_irq(irqs[2]));
	ttc_host ttc_host_inst (.i_core_clk(i_core_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wr(i_wr),
		.o_rd(i_rd), .o_be(i_be), .o_wdata(i_wdata));
	// 50 MHz clock
	initial begin
		i_core_clk = 1'b0;
		forever #10 i_core_clk = ~i_core_clk;
	end
	// ==================================================
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] sts();
		return 16'(8'h88 | (en_m << 4) | fl_m);
	endfunction
	function automatic logic [15:0] rst_val(input int a);
		if (a < 3) return 16'h0088;
		if (a == 3) return 16'h0000;
		if (a < 7) return 16'h0080;
		if (a < 10) return 16'h0088;
		if (a < 13) return 16'h0000;
		if (a < 19) return 16'hFFFF;
		return 16'h0000;
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// irq outputs are registered, so look two edges after the cause
	task automatic chk_irq();
		logic [2:0] e;
		e = 3'(en_m & fl_m);
		@(posedge i_core_clk);
		checks_done++;
		if (irqs !== e) begin
			mismatches++;
			$display("wrong value irqs expected %h seen %h", e, irqs);
		end
	endtask
	// bounded wait; running out counts as a mismatch
	task automatic wait_irq(input logic [2:0] m);
		int n;
		n = 0;
		while ((irqs & m) !== m) begin
			@(posedge i_core_clk);
			n++;
			if (n > 64) begin
				mismatches++;
				tally_and_finish();
			end
		end
	endtask
	// ==================================================
	// main sequence
	initial begin
		i_rst = 1'b1;
		i_standby = 1'b1;
		i_ext_clk = 4'h0;
		i_capture_a = 3'h0;
		i_capture_b = 3'h0;
		repeat (2) @(posedge i_core_clk);
		i_rst <= 1'b0;
		@(posedge i_core_clk);
		// standby holds every word at reset value, counters too; last word unmapped
		for (int a = 0; a < 20; a++) begin
			ttc_host_inst.rd(5'(a), v);
			chk16("reset word", rst_val(a), v);
		end
		i_standby <= 1'b0;
		// ones on flags and on the reserved bits change nothing there
		ttc_host_inst.wr(TTC_OFF_OVF, 2'h1, 16'h00FF);
		en_m = 7;
		ttc_host_inst.rd(TTC_OFF_OVF, v);
		chk16("status", sts(), v);
		// random data through single and double byte lanes
		for (int k = 0; k < 3; k++) begin
			r = 16'(xs());
			ttc_host_inst.wr(TTC_OFF_CHANNEL0_GENERAL_B + 5'(k), 2'(k + 1), r);
			ttc_host_inst.rd(TTC_OFF_CHANNEL0_GENERAL_B + 5'(k), v);
			chk16("byte lanes", {k > 0 ? r[15:8] : 8'hFF, k != 1 ? r[7:0] : 8'hFF}, v);
		end
		// all counters wrap; requests follow flag and enable
		for (int k = 0; k < 3; k++) ttc_host_inst.wr(TTC_OFF_CNT0 + 5'(k), 2'h3, 16'hFFF0);
		wait_irq(3'h7);
		fl_m = 7;
		chk_irq();
		ttc_host_inst.wr(TTC_OFF_OVF, 2'h1, 16'h0007);
		en_m = 0;
		chk_irq();
		ttc_host_inst.wr(TTC_OFF_OVF, 2'h1, 16'h0070);
		en_m = 7;
		chk_irq();
		ttc_host_inst.rd(TTC_OFF_OVF, v);
		chk16("status", sts(), v);
		ttc_host_inst.wr(TTC_OFF_OVF, 2'h1, 16'h0070);
		fl_m = 0;
		chk_irq();
		// channel 1 clears on its register A match; stale A flags cleared first
		ttc_host_inst.wr(TTC_OFF_CTRL0 + 5'h1, 2'h1, 16'h0020);
		ttc_host_inst.wr(TTC_OFF_CHANNEL0_GENERAL_A + 5'h1, 2'h3, 16'h0010);
		ttc_host_inst.rd(TTC_OFF_FLA, v);
		ttc_host_inst.wr(TTC_OFF_FLA, 2'h1, 16'h0000);
		ttc_host_inst.wr(TTC_OFF_CNT0 + 5'h1, 2'h3, 16'h0000);
		repeat (20) @(posedge i_core_clk);
		ttc_host_inst.rd(TTC_OFF_FLA, v);
		chk16("match flag", 16'h0001, {15'h0, v[1]});
		ttc_host_inst.rd(TTC_OFF_CNT0 + 5'h1, v);
		chk16("cleared count", 16'h0001, {15'h0, v <= 16'h0010});
		// channel 2 frozen on a quiet pin so the captured value is known
		ttc_host_inst.wr(TTC_OFF_CTRL0 + 5'h2, 2'h1, 16'h0004);
		r = 16'(xs());
		ttc_host_inst.wr(TTC_OFF_CNT0 + 5'h2, 2'h3, r);
		ttc_host_inst.wr(TTC_OFF_IOC0 + 5'h2, 2'h1, 16'h0004);
		i_capture_a <= 3'h4;
		repeat (4) @(posedge i_core_clk);
		i_capture_a <= 3'h0;
		repeat (4) @(posedge i_core_clk);
		ttc_host_inst.rd(TTC_OFF_CHANNEL0_GENERAL_A + 5'h2, v);
		chk16("captured", r, v);
		ttc_host_inst.rd(TTC_OFF_FLA, v);
		chk16("capture flag", 16'h0001, {15'h0, v[2]});
		// channel 2 phase counting: B leads A, so it counts down through zero
		ttc_host_inst.wr(TTC_OFF_MODE, 2'h1, 16'h0040);
		ttc_host_inst.wr(TTC_OFF_CNT0 + 5'h2, 2'h3, 16'h0001);
		for (int k = 0; k < 4; k++) begin
			i_ext_clk <= {2'h0, 2'(8'h1E >> (2 * k))};
			repeat (4) @(posedge i_core_clk);
		end
		ttc_host_inst.rd(TTC_OFF_CNT0 + 5'h2, v);
		chk16("phase count", 16'hFFFD, v);
		fl_m = 4;
		ttc_host_inst.rd(TTC_OFF_OVF, v);
		chk16("underflow status", sts(), v);
		chk_irq();
		// standby in mid-run restores reset values; it lands at the next edge
		i_standby <= 1'b1;
		@(posedge i_core_clk);
		ttc_host_inst.rd(TTC_OFF_CHANNEL0_GENERAL_A + 5'h2, v);
		chk16("standby gr", 16'hFFFF, v);
		ttc_host_inst.rd(TTC_OFF_CNT0 + 5'h2, v);
		chk16("standby count", 16'h0000, v);
		tally_and_finish();
	end
endmodule

// ---- tb/ttc_host.sv ----
`timescale 1ns/10ps
// ==================================================
// host cpu model: one strobe per access, held across the taking edge
module ttc_host (
	input wire logic i_core_clk,
	input wire logic [15:0] i_rdata,
	output logic [4:0] o_addr,
	output logic o_wr,
	output logic o_rd,
	output logic [1:0] o_be,
	output logic [15:0] o_wdata
);
	// idle values at time zero
	initial begin
		o_addr = 5'h1F;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_be = 2'h0;
		o_wdata = 16'h0000;
	end
	// word or byte write; idle data inverted so stale data never looks valid
	task automatic wr(input logic [4:0] a, input logic [1:0] be, input logic [15:0] d);
		o_addr <= a;
		o_be <= be;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_core_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d;
		@(posedge i_core_clk);
	endtask
	// read; a flag is cleared only by a write of zero after this returns it as one
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_core_clk);
		o_rd <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		d = i_rdata;
	endtask
endmodule
